// [trig_seq_params.svh]
`ifndef TRIG_SEQ_PARAMS_SVH
`define TRIG_SEQ_PARAMS_SVH

`define CLK_PERIOD_NS  40
`define DELAY_UNIT_NS  10000
`define TIMER_UNIT_NS  1000000
`define OUT_PULSE_NS   10000
`define DELAY_TICK_CYC (`DELAY_UNIT_NS / `CLK_PERIOD_NS)
`define TIMER_TICK_CYC (`TIMER_UNIT_NS / `CLK_PERIOD_NS)
`define OUT_PULSE_CYC  ((`OUT_PULSE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

`define DELAY_MAX      27'h5F5E0EC
`define TIMER_MAX      27'h5F5E0FF
`define TIMER_MIN      27'h0000001
`define COUNT_MAX      12'h9C4
`define LINE_MIN       3'h1
`define LINE_MAX       3'h6

`define AD_0MS5        27'h0000032
`define AD_1MS         27'h0000064
`define AD_2MS         27'h00000C8
`define AD_3MS         27'h000012C
`define AD_5MS         27'h00001F4
`define AD_10MS        27'h00003E8
`define AD_50MS        27'h0001388
`define AD_2500MS      27'h003D090

`endif

// [trig_seq_pkg.sv]
`include "trig_seq_params.svh"
package trig_seq_pkg;
    typedef enum logic [2:0] {
        S_IDLE  = 3'b000,
        S_ARM   = 3'b001,
        S_TRIG  = 3'b010,
        S_DELAY = 3'b011,
        S_CONV  = 3'b100
    } seq_state_t;

    typedef enum logic [2:0] {
        ARM_IMMEDIATE             = 3'b000,
        ARM_BUS                   = 3'b001,
        ARM_TIMER                 = 3'b010,
        ARM_MANUAL                = 3'b011,
        TRIGGER_LINE_SOURCE       = 3'b100,
        HANDLER_FALLING_START     = 3'b101,
        HANDLER_RISING_START      = 3'b110,
        HANDLER_EITHER_EDGE_START = 3'b111
    } arm_source_t;

    typedef enum logic {
        TRIG_IMMEDIATE = 1'b0,
        TRIG_LINE      = 1'b1
    } trig_source_t;

    // Lines 1..6 map to bits 0..5; anything else selects no line
    function automatic logic [5:0] line_onehot(input logic [2:0] sel);
        logic [5:0] oh;
        oh = 6'h00;
        if (sel >= `LINE_MIN && sel <= `LINE_MAX) begin
            oh[sel - 3'h1] = 1'b1;
        end
        return oh;
    endfunction : line_onehot
endpackage : trig_seq_pkg

// [trig_out_pulse.sv]
`include "trig_seq_params.svh"
module trig_out_pulse
    import trig_seq_pkg::*;
#(
    parameter int unsigned PULSE_CYCLES = `OUT_PULSE_CYC
) (
    input  wire logic       clk,
    input  wire logic       resetn,
    input  wire logic       fire,
    input  wire logic [2:0] line_sel,
    output logic      [5:0] drive_n
);
    logic [11:0] left;

    // A new event restarts the pulse rather than stretching a merged one
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            left    <= 12'h000;
            drive_n <= 6'h3F;
        end else if (fire) begin
            left    <= 12'(PULSE_CYCLES - 1);
            drive_n <= ~line_onehot(line_sel);
        end else if (left != 12'h000) begin
            left <= left - 12'h001;
        end else begin
            drive_n <= 6'h3F;
        end
    end
endmodule : trig_out_pulse

// [measurement_trigger_sequencer.sv]
`include "trig_seq_params.svh"
module measurement_trigger_sequencer
    import trig_seq_pkg::*;
#(
    parameter int unsigned RESULT_WIDTH      = 24,
    parameter int unsigned TIMER_TICK_CYCLES = `TIMER_TICK_CYC
) (
    input  wire logic                    CLK,
    input  wire logic                    RESETN,
    input  wire logic                    CMD_INITIATE,
    input  wire logic                    CMD_READ,
    input  wire logic                    CMD_ABORT,
    input  wire logic                    CMD_FETCH,
    input  wire logic                    CMD_CLEAR,
    input  wire logic                    BUS_TRIGGER,
    input  wire logic                    MANUAL_KEY,
    input  arm_source_t                  ARM_SOURCE,
    input  wire logic [11:0]             ARM_COUNT,
    input  wire logic                    ARM_COUNT_INF,
    input  wire logic [26:0]             ARM_TIMER_MS,
    input  wire logic                    ARM_BYPASS,
    input  wire logic [2:0]              ARM_INPUT_LINE_SELECT,
    input  wire logic [2:0]              ARM_OUTPUT_LINE_SELECT,
    input  wire logic                    ARM_OUTPUT_ENABLE,
    input  trig_source_t                 TRIG_SOURCE,
    input  wire logic [11:0]             TRIG_COUNT,
    input  wire logic                    TRIG_COUNT_INF,
    input  wire logic                    TRIG_BYPASS,
    input  wire logic [2:0]              TRIG_INPUT_LINE_SELECT,
    input  wire logic [2:0]              TRIG_OUTPUT_LINE_SELECT,
    input  wire logic                    MEAS_COMPLETE_ENABLE,
    input  wire logic [26:0]             MANUAL_DELAY,
    input  wire logic                    AUTO_DELAY,
    input  wire logic [1:0]              MEAS_FUNCTION,
    input  wire logic [3:0]              MEAS_RANGE,
    input  wire logic                    FILTER_REPEAT,
    input  wire logic                    FILTER_MOVING,
    input  wire logic [6:0]              FILTER_COUNT,
    input  wire logic [5:0]              TRIG_LINK_IN,
    input  wire logic                    HANDLER_START_LINE,
    input  wire logic                    CONV_DONE,
    input  wire logic [RESULT_WIDTH-1:0] CONV_RESULT,
    output logic      [5:0]              TRIG_LINK_OUT,
    output logic      [5:0]              TRIG_LINK_OE_N,
    output logic                         CONV_START,
    output logic      [RESULT_WIDTH-1:0] RESULT,
    output logic                         FRESH_VALID,
    output logic                         FETCH_VALID,
    output logic                         IDLE,
    output logic                         LINE_CONFLICT
);
    default clocking @(posedge CLK); endclocking
    default disable iff (!RESETN);

    seq_state_t  state;
    logic [6:0]  pin_meta, pin_sync, pin_last;
    logic [5:0]  link_fall, link_pend, link_take;
    logic        hs_rise_pend, hs_fall_pend;
    logic [5:0]  arm_in_oh, trig_in_oh;
    logic        arm_link_hit, trig_link_hit;
    logic        arm_bypass_armed, trig_bypass_armed;
    logic        arm_event, trig_event, abort_ok, start_ok;
    logic        read_active;
    logic [14:0] ms_cnt;
    logic [26:0] timer_ms;
    logic        timer_hit, timer_first, ms_tick;
    logic [7:0]  tick_cnt;
    logic        tick;
    logic [26:0] delay_left;
    logic [6:0]  conv_left, fill_cnt, conv_need;
    logic [11:0] trig_cnt, arm_cnt;
    logic        finish, last_trig, last_arm;
    logic        measurement_complete_pulse, arm_out_fire;
    logic [5:0]  meas_drive_n, arm_drive_n;

    function automatic logic count_done(input logic [11:0] cnt,
                                        input logic [11:0] limit,
                                        input logic        inf);
        logic [11:0] lim;
        lim = (limit == 12'h000) ? 12'h001 :
              (limit > `COUNT_MAX) ? `COUNT_MAX : limit;
        return !inf && (cnt + 12'h001 >= lim);
    endfunction : count_done

    function automatic logic [26:0] auto_delay(input logic [1:0] fn,
                                               input logic [3:0] rng);
        logic [26:0] d;
        d = `AD_10MS;
        case (fn)
            2'h0: d = (rng == 4'h0) ? `AD_5MS : (rng == 4'h1) ? `AD_3MS : `AD_2MS;
            2'h1: begin
                if (rng <= 4'h1)      d = `AD_2500MS;
                else if (rng <= 4'h5) d = `AD_10MS;
                else if (rng <= 4'h7) d = `AD_5MS;
                else if (rng == 4'h8) d = `AD_1MS;
                else                  d = `AD_0MS5;
            end
            2'h2: begin
                if (rng == 4'h0)      d = `AD_5MS;
                else if (rng <= 4'h2) d = `AD_1MS;
                else if (rng <= 4'h5) d = `AD_10MS;
                else                  d = `AD_50MS;
            end
            default: d = `AD_3MS;
        endcase
        return d;
    endfunction : auto_delay

    // Pins are asynchronous; only pin_sync and pin_last feed logic
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            pin_meta <= 7'h7F;
            pin_sync <= 7'h7F;
            pin_last <= 7'h7F;
        end else begin
            pin_meta <= {HANDLER_START_LINE, TRIG_LINK_IN};
            pin_sync <= pin_meta;
            pin_last <= pin_sync;
        end
    end

    assign link_fall = pin_last[5:0] & ~pin_sync[5:0];
    assign arm_in_oh     = line_onehot(ARM_INPUT_LINE_SELECT);
    assign trig_in_oh    = line_onehot(TRIG_INPUT_LINE_SELECT);
    assign arm_link_hit  = |(link_pend & arm_in_oh);
    assign trig_link_hit = |(link_pend & trig_in_oh);
    assign abort_ok = CMD_ABORT && !read_active;
    assign start_ok = (state == S_IDLE) && (CMD_INITIATE || CMD_READ);

    always_comb begin
        case (ARM_SOURCE)
            ARM_IMMEDIATE:             arm_event = 1'b1;
            ARM_BUS:                   arm_event = BUS_TRIGGER;
            ARM_TIMER:                 arm_event = timer_first || timer_hit;
            ARM_MANUAL:                arm_event = MANUAL_KEY;
            TRIGGER_LINE_SOURCE:       arm_event = (ARM_BYPASS && arm_bypass_armed)
                                                   || arm_link_hit;
            HANDLER_FALLING_START:     arm_event = hs_fall_pend;
            HANDLER_RISING_START:      arm_event = hs_rise_pend;
            HANDLER_EITHER_EDGE_START: arm_event = hs_fall_pend || hs_rise_pend;
            default:                   arm_event = 1'b0;
        endcase
    end

    assign trig_event = (TRIG_SOURCE == TRIG_IMMEDIATE) ||
                        (TRIG_BYPASS && trig_bypass_armed) || trig_link_hit;

    // A bypassed pass leaves any latched trigger for the next pass
    always_comb begin
        link_take = 6'h00;
        if (state == S_ARM && ARM_SOURCE == TRIGGER_LINE_SOURCE &&
            !(ARM_BYPASS && arm_bypass_armed)) begin
            link_take = link_take | arm_in_oh;
        end
        if (state == S_TRIG && TRIG_SOURCE == TRIG_LINE &&
            !(TRIG_BYPASS && trig_bypass_armed)) begin
            link_take = link_take | trig_in_oh;
        end
    end

    // clear pending triggers; a new edge wins over the clear
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            link_pend    <= 6'h00;
            hs_rise_pend <= 1'b0;
            hs_fall_pend <= 1'b0;
        end else begin
            link_pend <= (link_pend & ~link_take & {6{!CMD_CLEAR}}) | link_fall;
            hs_rise_pend <= (hs_rise_pend && !CMD_CLEAR &&
                             !(state == S_ARM && arm_event)) ||
                            (pin_sync[6] && !pin_last[6]);
            hs_fall_pend <= (hs_fall_pend && !CMD_CLEAR &&
                             !(state == S_ARM && arm_event)) ||
                            (!pin_sync[6] && pin_last[6]);
        end
    end

    // arm timer in milliseconds, restarted in idle
    assign ms_tick = (ms_cnt == 15'(TIMER_TICK_CYCLES - 1));
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            ms_cnt      <= 15'h0000;
            timer_ms    <= 27'h0000000;
            timer_hit   <= 1'b0;
            timer_first <= 1'b1;
        end else if (state == S_IDLE) begin
            ms_cnt      <= 15'h0000;
            timer_ms    <= 27'h0000000;
            timer_hit   <= 1'b0;
            timer_first <= 1'b1;
        end else begin
            ms_cnt <= ms_tick ? 15'h0000 : ms_cnt + 15'h0001;
            if (state == S_ARM && ARM_SOURCE == ARM_TIMER && arm_event) begin
                timer_first <= 1'b0;
                timer_hit   <= 1'b0;
            end
            if (ms_tick) begin
                if (timer_ms + 27'h1 >= ((ARM_TIMER_MS < `TIMER_MIN) ? `TIMER_MIN :
                    (ARM_TIMER_MS > `TIMER_MAX) ? `TIMER_MAX : ARM_TIMER_MS)) begin
                    timer_ms  <= 27'h0000000;
                    timer_hit <= 1'b1;
                end else begin
                    timer_ms <= timer_ms + 27'h1;
                end
            end
        end
    end

    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            arm_bypass_armed  <= 1'b1;
            trig_bypass_armed <= 1'b1;
        end else if (state == S_IDLE) begin
            arm_bypass_armed  <= 1'b1;
            trig_bypass_armed <= 1'b1;
        end else begin
            if (state == S_ARM && arm_event) begin
                arm_bypass_armed <= !(ARM_SOURCE == TRIGGER_LINE_SOURCE && ARM_BYPASS);
                trig_bypass_armed <= 1'b1;
            end
            if (state == S_TRIG && trig_event && TRIG_SOURCE == TRIG_LINE) begin
                trig_bypass_armed <= 1'b0;
            end
        end
    end

    assign tick      = (tick_cnt == 8'(`DELAY_TICK_CYC - 1));
    assign finish    = (state == S_CONV) && CONV_DONE && (conv_left <= 7'h01);
    assign last_trig = count_done(trig_cnt, TRIG_COUNT, TRIG_COUNT_INF);
    assign last_arm  = count_done(arm_cnt, ARM_COUNT, ARM_COUNT_INF);

    always_comb begin
        if (FILTER_REPEAT) begin
            conv_need = FILTER_COUNT;
        end else if (FILTER_MOVING && fill_cnt < FILTER_COUNT) begin
            conv_need = FILTER_COUNT - fill_cnt;
        end else begin
            conv_need = 7'h01;
        end
        if (conv_need == 7'h00) begin
            conv_need = 7'h01;
        end
    end

    // Sequencer; abort wins, but not over a running read
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            state       <= S_IDLE;
            read_active <= 1'b0;
            trig_cnt    <= 12'h000;
            arm_cnt     <= 12'h000;
            delay_left  <= 27'h0000000;
            tick_cnt    <= 8'h00;
            conv_left   <= 7'h00;
            CONV_START  <= 1'b0;
        end else begin
            CONV_START <= 1'b0;
            tick_cnt   <= tick ? 8'h00 : tick_cnt + 8'h01;
            if (abort_ok) begin
                state <= S_IDLE;
            end else begin
                case (state)
                    S_IDLE: begin
                        // initiate or read starts a cycle
                        if (start_ok) begin
                            state       <= S_ARM;
                            read_active <= CMD_READ;
                            arm_cnt     <= 12'h000;
                        end else begin
                            read_active <= 1'b0;
                        end
                    end
                    S_ARM: if (arm_event) begin
                        state    <= S_TRIG;
                        trig_cnt <= 12'h000;
                    end
                    S_TRIG: if (trig_event) begin
                        state    <= S_DELAY;
                        tick_cnt <= 8'h00;
                        delay_left <= AUTO_DELAY ? auto_delay(MEAS_FUNCTION, MEAS_RANGE) :
                                      (MANUAL_DELAY > `DELAY_MAX) ? `DELAY_MAX : MANUAL_DELAY;
                    end
                    S_DELAY: begin
                        if (delay_left == 27'h0000000) begin
                            state      <= S_CONV;
                            conv_left  <= conv_need;
                            CONV_START <= 1'b1;
                        end else if (tick) begin
                            delay_left <= delay_left - 27'h1;
                        end
                    end
                    S_CONV: if (CONV_DONE) begin
                        if (conv_left > 7'h01) begin
                            conv_left  <= conv_left - 7'h01;
                            CONV_START <= 1'b1;
                        end else if (!last_trig) begin
                            state    <= S_TRIG;
                            trig_cnt <= trig_cnt + 12'h001;
                        end else if (!last_arm) begin
                            state   <= S_ARM;
                            arm_cnt <= arm_cnt + 12'h001;
                        end else begin
                            state <= S_IDLE;
                        end
                    end
                    default: state <= S_IDLE;
                endcase
            end
        end
    end

    // Moving window fill survives idle, as the filter keeps its history
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            fill_cnt <= 7'h00;
        end else if (!FILTER_MOVING) begin
            fill_cnt <= 7'h00;
        end else if (state == S_CONV && CONV_DONE && fill_cnt < FILTER_COUNT) begin
            fill_cnt <= fill_cnt + 7'h01;
        end
    end

    // read streams fresh results, fetch repeats the stored one
    always_ff @(posedge CLK or negedge RESETN) begin
        if (!RESETN) begin
            RESULT      <= '0;
            FRESH_VALID <= 1'b0;
            FETCH_VALID <= 1'b0;
        end else begin
            FRESH_VALID <= finish && !abort_ok && read_active;
            FETCH_VALID <= CMD_FETCH;
            // result only moves on a finished action
            if (finish && !abort_ok) begin
                RESULT <= CONV_RESULT;
            end
        end
    end

    // same line for input and output blocks the output pulse
    assign LINE_CONFLICT = (ARM_INPUT_LINE_SELECT == ARM_OUTPUT_LINE_SELECT) ||
                           (TRIG_INPUT_LINE_SELECT == TRIG_OUTPUT_LINE_SELECT);
    assign measurement_complete_pulse = finish && !abort_ok && MEAS_COMPLETE_ENABLE &&
                                        !LINE_CONFLICT;
    assign arm_out_fire = finish && !abort_ok && last_trig && ARM_OUTPUT_ENABLE &&
                          !LINE_CONFLICT;

    trig_out_pulse u_meas_pulse (
        .clk      (CLK),
        .resetn   (RESETN),
        .fire     (measurement_complete_pulse),
        .line_sel (TRIG_OUTPUT_LINE_SELECT),
        .drive_n  (meas_drive_n)
    );
    trig_out_pulse u_arm_pulse (
        .clk      (CLK),
        .resetn   (RESETN),
        .fire     (arm_out_fire),
        .line_sel (ARM_OUTPUT_LINE_SELECT),
        .drive_n  (arm_drive_n)
    );
    assign TRIG_LINK_OE_N = meas_drive_n & arm_drive_n;
    assign TRIG_LINK_OUT  = 6'h00;
    assign IDLE           = (state == S_IDLE);

    chk_abort_idle: assert property (abort_ok |=> state == S_IDLE)
        else $error("abort did not reach idle");
    chk_initiate_start: assert property (start_ok && !CMD_ABORT |=> state == S_ARM)
        else $error("initiate did not leave idle");
    chk_idle_frozen: assert property ((state == S_IDLE)[*2] |-> !CONV_START && $stable(RESULT))
        else $error("activity while idle");
    chk_delay_step: assert property (state == S_DELAY && delay_left != 0 && tick && !abort_ok
        |=> delay_left == $past(delay_left) - 27'h1)
        else $error("delay did not count down");
    chk_clear_pend: assert property (CMD_CLEAR && link_fall == 6'h00 |=> link_pend == 6'h00)
        else $error("pending trigger survived clear");
    chk_single_conv: assert property (state == S_DELAY && delay_left == 0 && !abort_ok &&
        !FILTER_REPEAT && !FILTER_MOVING |=> conv_left == 7'h01 && CONV_START)
        else $error("more than one conversion");
    chk_repeat_conv: assert property (state == S_DELAY && delay_left == 0 && !abort_ok &&
        FILTER_REPEAT && FILTER_COUNT != 0 |=> conv_left == $past(FILTER_COUNT))
        else $error("repeat filter count wrong");
    chk_trig_loop: assert property (finish && !abort_ok && !last_trig |=> state == S_TRIG)
        else $error("trigger layer did not repeat");
    chk_timer_first: assert property (state == S_ARM && ARM_SOURCE == ARM_TIMER &&
        timer_first && !abort_ok |=> state == S_TRIG)
        else $error("first timer pass not immediate");
    // The arm pulse unit may pull other lines at the same time, so only the chosen bit is ours
    chk_pulse_low: assert property (measurement_complete_pulse
        |=> (TRIG_LINK_OE_N & line_onehot($past(TRIG_OUTPUT_LINE_SELECT))) == 6'h00)
        else $error("output pulse not driven");
endmodule : measurement_trigger_sequencer

// [link_partner.sv]
module link_partner (
    input  wire logic       clk,
    input  wire logic       fire,
    input  wire logic [2:0] line,
    input  wire logic [5:0] oe_n,
    output logic      [5:0] pins
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [1:0] cnt = 2'h0;
    logic [5:0] drv = 6'h00;
    // falling pulse held low four cycles
    always_ff @(posedge clk) begin
        if (fire) begin
            cnt <= 2'h3;
            drv <= 6'h01 << (line - 3'h1);
        end else if (cnt != 2'h0) begin
            cnt <= cnt - 2'h1;
        end else begin
            drv <= 6'h00;
        end
    end
    // Pulled up: low while either side drives
    assign pins = ~drv & oe_n;
endmodule : link_partner

// [tb_top.sv]
module tb_top;
    import trig_seq_pkg::*;
    timeunit 1ns;
    timeprecision 1ns;
    logic CLK = 0, RESETN = 0, CMD_INITIATE = 0, CMD_READ = 0, CMD_ABORT = 0, CMD_FETCH = 0;
    logic CMD_CLEAR = 0, BUS_TRIGGER = 0, MANUAL_KEY = 0, ARM_COUNT_INF = 0, ARM_BYPASS = 0;
    logic ARM_OUTPUT_ENABLE = 0, TRIG_COUNT_INF = 0, TRIG_BYPASS = 0, MEAS_COMPLETE_ENABLE = 0;
    logic AUTO_DELAY = 0, FILTER_REPEAT = 0, FILTER_MOVING = 0, HANDLER_START_LINE = 1;
    logic CONV_DONE = 0, CONV_START, FRESH_VALID, FETCH_VALID, IDLE, LINE_CONFLICT, pfire = 0;
    arm_source_t  ARM_SOURCE = ARM_IMMEDIATE;
    trig_source_t TRIG_SOURCE = TRIG_IMMEDIATE;
    logic [11:0] ARM_COUNT = 12'h001, TRIG_COUNT = 12'h001;
    logic [26:0] ARM_TIMER_MS = 27'h0000064, MANUAL_DELAY = 27'h0000000;
    logic [2:0]  ARM_INPUT_LINE_SELECT = 3'h1, TRIG_INPUT_LINE_SELECT = 3'h1, pline = 3'h1;
    logic [2:0]  ARM_OUTPUT_LINE_SELECT = 3'h2, TRIG_OUTPUT_LINE_SELECT = 3'h2;
    logic [1:0]  MEAS_FUNCTION = 2'h0;
    logic [3:0]  MEAS_RANGE = 4'h0;
    logic [6:0]  FILTER_COUNT = 7'h01;
    logic [23:0] CONV_RESULT = 24'h000000, RESULT;
    logic [5:0]  TRIG_LINK_IN, TRIG_LINK_OUT, TRIG_LINK_OE_N;
    int          fails = 0, checks = 0, nconv = 0, nfresh = 0, nfetch = 0, n;
    // Short millisecond tick keeps the timer scenario within the run
    measurement_trigger_sequencer #(.TIMER_TICK_CYCLES(10))
        i_measurement_trigger_sequencer (.*);
    link_partner i_link_partner (.clk(CLK), .fire(pfire), .line(pline), .oe_n(TRIG_LINK_OE_N),
                                 .pins(TRIG_LINK_IN));
    initial forever #20 CLK = ~CLK;
    task check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            fails++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task results;
        if (fails == 0 && checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask : results
    // Converter answers one cycle after each start with a running count
    always @(posedge CLK) begin
        CONV_DONE <= CONV_START;
        if (CONV_START) begin
            CONV_RESULT <= CONV_RESULT + 24'h000001;
            nconv <= nconv + 1;
        end
        if (FRESH_VALID) nfresh <= nfresh + 1;
        if (FETCH_VALID) begin
            nfetch <= nfetch + 1;
            check("fetch", RESULT, nconv);
        end
    end
    task go(input logic rd);
        @(posedge CLK);
        CMD_INITIATE <= !rd;
        CMD_READ <= rd;
        @(posedge CLK);
        CMD_INITIATE <= 1'b0;
        CMD_READ <= 1'b0;
    endtask : go
    task wait_idle;
        n = 0;
        repeat (3) @(negedge CLK);
        while (IDLE !== 1'b1 && n < 3000) begin
            @(negedge CLK);
            n++;
        end
        if (IDLE !== 1'b1) fails++;
        // Second edge lets counters bumped at the first edge settle
        repeat (2) @(posedge CLK);
    endtask : wait_idle
    // Bit 3 abort, 2 fetch, 1 clear, 0 bus trigger
    task strobe(input int k);
        @(posedge CLK);
        {CMD_ABORT, CMD_FETCH, CMD_CLEAR, BUS_TRIGGER} <= 4'h1 << k;
        @(posedge CLK);
        {CMD_ABORT, CMD_FETCH, CMD_CLEAR, BUS_TRIGGER} <= 4'h0;
    endtask : strobe
    task link_pulse;
        @(posedge CLK);
        pfire <= 1'b1;
        @(posedge CLK);
        pfire <= 1'b0;
    endtask : link_pulse
    initial begin
        repeat (8) @(posedge CLK);
        check("idle", IDLE, 32'h1);
        check("oe", TRIG_LINK_OE_N, 32'h3F);
        check("out", TRIG_LINK_OUT, 32'h0);
        RESETN <= 1'b1;
        go(0); wait_idle;
        check("result", RESULT, 32'h1);
        ARM_COUNT <= 12'h002;
        TRIG_COUNT <= 12'h003;
        go(1); wait_idle;
        check("conv", nconv, 32'h7);
        check("fresh", nfresh, 32'h6);
        strobe(2); repeat (3) @(posedge CLK);
        check("fetched", nfetch, 32'h1);
        check("conv", nconv, 32'h7);
        {ARM_COUNT, TRIG_COUNT, FILTER_REPEAT, FILTER_COUNT} <= {12'h001, 12'h001, 1'b1, 7'h04};
        go(0); wait_idle;
        check("conv", nconv, 32'hB);
        check("result", RESULT, 32'hB);
        FILTER_REPEAT <= 1'b0;
        MEAS_COMPLETE_ENABLE <= 1'b1;
        go(0); wait_idle;
        check("oe", TRIG_LINK_OE_N, 32'h3D);
        repeat (252) @(posedge CLK);
        check("oe", TRIG_LINK_OE_N, 32'h3F);
        TRIG_INPUT_LINE_SELECT <= 3'h2;
        go(0); wait_idle;
        check("conflict", LINE_CONFLICT, 32'h1);
        check("oe", TRIG_LINK_OE_N, 32'h3F);
        {TRIG_INPUT_LINE_SELECT, MEAS_COMPLETE_ENABLE, ARM_OUTPUT_ENABLE} <= {3'h1, 1'b0, 1'b1};
        go(0); wait_idle;
        check("oe", TRIG_LINK_OE_N, 32'h3D);
        ARM_OUTPUT_ENABLE <= 1'b0;
        ARM_SOURCE <= ARM_BUS;
        repeat (252) @(posedge CLK);
        go(0); repeat (20) @(posedge CLK);
        check("conv", nconv, 32'hE);
        strobe(0); wait_idle;
        check("conv", nconv, 32'hF);
        ARM_SOURCE <= ARM_IMMEDIATE;
        TRIG_SOURCE <= TRIG_LINE;
        link_pulse; repeat (8) @(posedge CLK);
        strobe(1);
        go(0); repeat (20) @(posedge CLK);
        check("conv", nconv, 32'hF);
        link_pulse; wait_idle;
        check("conv", nconv, 32'h10);
        go(0); repeat (5) @(posedge CLK);
        check("idle", IDLE, 32'h0);
        strobe(3); repeat (3) @(posedge CLK);
        check("idle", IDLE, 32'h1);
        check("conv", nconv, 32'h10);
        {TRIG_BYPASS, TRIG_COUNT} <= {1'b1, 12'h002};
        go(0); repeat (20) @(posedge CLK);
        check("conv", nconv, 32'h11);
        link_pulse; wait_idle;
        check("conv", nconv, 32'h12);
        {TRIG_BYPASS, TRIG_COUNT, FILTER_MOVING, FILTER_COUNT} <= {1'b0, 12'h001, 1'b1, 7'h02};
        TRIG_SOURCE <= TRIG_IMMEDIATE;
        go(0); wait_idle;
        check("conv", nconv, 32'h14);
        go(0); wait_idle;
        check("conv", nconv, 32'h15);
        {FILTER_MOVING, ARM_COUNT, ARM_TIMER_MS} <= {1'b0, 12'h002, 27'h0000005};
        ARM_SOURCE <= ARM_TIMER;
        go(0); repeat (20) @(posedge CLK);
        check("conv", nconv, 32'h16);
        wait_idle;
        check("conv", nconv, 32'h17);
        {ARM_COUNT, MANUAL_DELAY} <= {12'h001, 27'h0000001};
        ARM_SOURCE <= ARM_IMMEDIATE;
        go(1); repeat (100) @(posedge CLK);
        strobe(3);
        check("idle", IDLE, 32'h0);
        check("conv", nconv, 32'h17);
        wait_idle;
        check("conv", nconv, 32'h18);
        check("fresh", nfresh, 32'h7);
        results;
    end
    initial begin
        repeat (20000) @(posedge CLK);
        fails++;
        results;
    end
endmodule : tb_top
